// [rtl/dci_pkg.sv]
// Constants, carrier types and states of the debug command interpreter.
// Operation
// - Command 00H returns major then minor revision.
// - Command 02H returns the status register byte.
// - Saturating 16-bit cycle tally, read by 03H.
// - Access, checksum and CPU commands clobber the tally.
// - Command 04H loads bits 7, 6 and 0 of following byte into control.
// - Read protection lets debug bit only be set.
// - Command 05H returns the control register byte.
// - Command 0EH returns program memory CCITT checksum.
// - Checksum outside debug mode returns FFFFH.
// - Checksum reads each byte, one clock each.
// - Command 10H steps once when allowed.
// - Command 11H runs instruction with sent opcode.
// - Stuff fetches one following byte; ignored when blocked.
// - Command 12H executes a one-to-seven byte instruction.
// - Blocked execute consumes one byte, runs nothing.
// - Control gives debug entry, breakpoint enable, reset.
package dci_pkg;

	localparam int unsigned BYTE_W = 8;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned LEN_W = 3;

	localparam logic [7:0] CMD_READ_REV = 8'h00;
	localparam logic [7:0] CMD_READ_STAT = 8'h02;
	localparam logic [7:0] CMD_READ_TALLY = 8'h03;
	localparam logic [7:0] CMD_WRITE_CTL = 8'h04;
	localparam logic [7:0] CMD_READ_CTL = 8'h05;
	localparam logic [7:0] CMD_ACCESS_FIRST = 8'h08;
	localparam logic [7:0] CMD_ACCESS_LAST = 8'h0d;
	localparam logic [7:0] CMD_CRC = 8'h0e;
	localparam logic [7:0] CMD_STEP = 8'h10;
	localparam logic [7:0] CMD_STUFF = 8'h11;
	localparam logic [7:0] CMD_EXEC = 8'h12;

	localparam int unsigned CTL_DEBUG_BIT = 7;
	localparam int unsigned CTL_BRK_BIT = 6;
	localparam int unsigned CTL_RESET_BIT = 0;
	localparam logic [7:0] CTL_RESET_VALUE = 8'h00;
	localparam logic [7:0] CTL_WRITE_MASK = 8'hc1;

	localparam int unsigned STAT_DEBUG_BIT = 7;
	localparam int unsigned STAT_HALT_BIT = 6;
	localparam int unsigned STAT_PROTECT_BIT = 5;

	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_BLOCKED = 16'hffff;
	localparam logic [15:0] TALLY_ZERO = 16'h0000;
	localparam logic [15:0] TALLY_MAX = 16'hffff;

	localparam logic [1:0] RESP_NONE = 2'h0;
	localparam logic [1:0] RESP_ONE = 2'h1;
	localparam logic [1:0] RESP_TWO = 2'h2;
	localparam logic [LEN_W-1:0] LEN_ONE = 3'h1;

	typedef struct packed {
		logic step;
		logic stuff;
		logic exec_valid;
		logic exec_last;
		logic [7:0] data;
	} dci_cpu_cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_GET_CTL,
		ST_GET_STUFF,
		ST_EXEC_FIRST,
		ST_EXEC_REST,
		ST_DISCARD,
		ST_CRC_RUN,
		ST_CRC_DRAIN,
		ST_CRC_DONE
	} dci_state_t;

endpackage : dci_pkg

// [rtl/dci_crc16.sv]
// Byte-wide CRC-CCITT accumulator, most significant bit first.
module dci_crc16
	import dci_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic init,
	input wire logic enable,
	input wire logic [BYTE_W-1:0] data,
	output logic [WORD_W-1:0] crc
);
	logic [WORD_W-1:0] next_crc;

	always_comb
	begin
		next_crc = crc;
		for (int i = BYTE_W - 1; i >= 0; i--)
		begin
			if (next_crc[WORD_W-1] ^ data[i])
			begin
				next_crc = {next_crc[WORD_W-2:0], 1'b0} ^ CRC_POLY;
			end
			else
			begin
				next_crc = {next_crc[WORD_W-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || init)
		begin
			crc <= CRC_INIT;
		end
		else if (enable)
		begin
			crc <= next_crc;
		end
	end

endmodule : dci_crc16

// [rtl/dci_top.sv]
// Debug command interpreter: decodes host command bytes and carries them out.
module dci_top
	import dci_pkg::*;
#(
	parameter int unsigned PMEM_BYTES = 2048,
	parameter int unsigned ADDR_W = 11,
	parameter logic [7:0] REV_MAJOR = 8'h01,
	parameter logic [7:0] REV_MINOR = 8'h00
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic [BYTE_W-1:0] rx_byte,
	input wire logic [LEN_W-1:0] insn_len,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [BYTE_W-1:0] tx_byte,
	input wire logic read_protect,
	input wire logic cpu_halted,
	output logic pmem_rd,
	output logic [ADDR_W-1:0] pmem_addr,
	input wire logic [BYTE_W-1:0] pmem_data,
	output dci_pkg::dci_cpu_cmd_t cpu_cmd,
	output logic [BYTE_W-1:0] debugger_control_reg,
	output logic [BYTE_W-1:0] debugger_status_reg,
	output logic halted_debug_flag,
	output logic brk_enable,
	output logic device_reset_req
);
	import dci_pkg::*;

	localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(PMEM_BYTES - 1);
	localparam logic [ADDR_W-1:0] ADDR_ZERO = '0;

	dci_state_t state;
	logic [BYTE_W-1:0] ctl;
	logic [WORD_W-1:0] cycle_tally;
	logic [WORD_W-1:0] resp;
	logic [1:0] resp_cnt;
	logic [LEN_W-1:0] exec_left;
	logic rd_pending;
	logic [WORD_W-1:0] crc_value;
	logic take;
	logic allowed;
	logic clobber;
	logic crc_start;
	logic debug_prev;
	logic load_resp;
	logic [WORD_W-1:0] load_value;
	logic [1:0] load_count;
	logic [LEN_W-1:0] first_len;
	logic [BYTE_W-1:0] next_ctl;

	assign take = rx_valid && (state == ST_IDLE);
	assign allowed = ctl[CTL_DEBUG_BIT] && !read_protect;
	assign halted_debug_flag = ctl[CTL_DEBUG_BIT];
	assign brk_enable = ctl[CTL_BRK_BIT];
	assign debugger_control_reg = ctl;
	assign crc_start = take && (rx_byte == CMD_CRC) && ctl[CTL_DEBUG_BIT];
	assign pmem_rd = (state == ST_CRC_RUN);
	assign first_len = (insn_len == '0) ? LEN_ONE : insn_len;

	always_comb
	begin
		debugger_status_reg = '0;
		debugger_status_reg[STAT_DEBUG_BIT] = ctl[CTL_DEBUG_BIT];
		debugger_status_reg[STAT_HALT_BIT] = cpu_halted;
		debugger_status_reg[STAT_PROTECT_BIT] = read_protect;
	end

	always_comb
	begin
		clobber = 1'b0;
		if (take)
		begin
			if ((rx_byte >= CMD_ACCESS_FIRST) && (rx_byte <= CMD_ACCESS_LAST))
			begin
				clobber = 1'b1;
			end
			if ((rx_byte == CMD_CRC) || (rx_byte == CMD_STEP))
			begin
				clobber = 1'b1;
			end
			if ((rx_byte == CMD_STUFF) || (rx_byte == CMD_EXEC))
			begin
				clobber = 1'b1;
			end
		end
	end

	always_comb
	begin
		load_resp = 1'b0;
		load_value = '0;
		load_count = RESP_NONE;
		if (take)
		begin
			case (rx_byte)
				CMD_READ_REV:
				begin
					load_resp = 1'b1;
					load_value = {REV_MAJOR, REV_MINOR};
					load_count = RESP_TWO;
				end
				CMD_READ_STAT:
				begin
					load_resp = 1'b1;
					load_value = {debugger_status_reg, 8'h00};
					load_count = RESP_ONE;
				end
				CMD_READ_TALLY:
				begin
					load_resp = 1'b1;
					load_value = cycle_tally;
					load_count = RESP_TWO;
				end
				CMD_READ_CTL:
				begin
					load_resp = 1'b1;
					load_value = {ctl, 8'h00};
					load_count = RESP_ONE;
				end
				CMD_CRC:
				begin
					if (!ctl[CTL_DEBUG_BIT])
					begin
						load_resp = 1'b1;
						load_value = CRC_BLOCKED;
						load_count = RESP_TWO;
					end
				end
				default:
				begin
					load_resp = 1'b0;
				end
			endcase
		end
		else if (state == ST_CRC_DONE)
		begin
			load_resp = 1'b1;
			load_value = crc_value;
			load_count = RESP_TWO;
		end
	end

	always_comb
	begin
		next_ctl = (rx_byte & CTL_WRITE_MASK) | (ctl & ~CTL_WRITE_MASK);
		if (read_protect && ctl[CTL_DEBUG_BIT])
		begin
			next_ctl[CTL_DEBUG_BIT] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (take)
					begin
						case (rx_byte)
							CMD_WRITE_CTL:
							begin
								state <= ST_GET_CTL;
							end
							CMD_STUFF:
							begin
								state <= allowed ? ST_GET_STUFF : ST_IDLE;
							end
							CMD_EXEC:
							begin
								state <= allowed ? ST_EXEC_FIRST : ST_DISCARD;
							end
							CMD_CRC:
							begin
								state <= ctl[CTL_DEBUG_BIT] ? ST_CRC_RUN : ST_IDLE;
							end
							default:
							begin
								state <= ST_IDLE;
							end
						endcase
					end
				end
				ST_GET_CTL, ST_GET_STUFF, ST_DISCARD:
				begin
					if (rx_valid)
					begin
						state <= ST_IDLE;
					end
				end
				ST_EXEC_FIRST:
				begin
					if (rx_valid)
					begin
						state <= (first_len == LEN_ONE) ? ST_IDLE : ST_EXEC_REST;
					end
				end
				ST_EXEC_REST:
				begin
					if (rx_valid && (exec_left == LEN_ONE))
					begin
						state <= ST_IDLE;
					end
				end
				ST_CRC_RUN:
				begin
					if (pmem_addr == ADDR_LAST)
					begin
						state <= ST_CRC_DRAIN;
					end
				end
				ST_CRC_DRAIN:
				begin
					state <= ST_CRC_DONE;
				end
				ST_CRC_DONE:
				begin
					state <= ST_IDLE;
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			exec_left <= '0;
		end
		else if ((state == ST_EXEC_FIRST) && rx_valid)
		begin
			exec_left <= LEN_W'(first_len - LEN_ONE);
		end
		else if ((state == ST_EXEC_REST) && rx_valid)
		begin
			exec_left <= LEN_W'(exec_left - LEN_ONE);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctl <= CTL_RESET_VALUE;
		end
		else if ((state == ST_GET_CTL) && rx_valid)
		begin
			ctl <= next_ctl;
		end
		else
		begin
			ctl[CTL_RESET_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			device_reset_req <= 1'b0;
		end
		else
		begin
			device_reset_req <= ctl[CTL_RESET_BIT];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			debug_prev <= 1'b0;
		end
		else
		begin
			debug_prev <= ctl[CTL_DEBUG_BIT];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || clobber)
		begin
			cycle_tally <= TALLY_ZERO;
		end
		else if (debug_prev && !ctl[CTL_DEBUG_BIT])
		begin
			cycle_tally <= TALLY_ZERO;
		end
		else if (!ctl[CTL_DEBUG_BIT] && (cycle_tally != TALLY_MAX))
		begin
			cycle_tally <= WORD_W'(cycle_tally + 1'b1);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || crc_start)
		begin
			pmem_addr <= ADDR_ZERO;
		end
		else if ((state == ST_CRC_RUN) && (pmem_addr != ADDR_LAST))
		begin
			pmem_addr <= ADDR_W'(pmem_addr + 1'b1);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rd_pending <= 1'b0;
		end
		else
		begin
			rd_pending <= pmem_rd;
		end
	end

	dci_crc16 dci_crc16_inst (
		.ref_clk(ref_clk),
		.reset(reset),
		.init(crc_start),
		.enable(rd_pending),
		.data(pmem_data),
		.crc(crc_value)
	);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			resp <= '0;
			resp_cnt <= RESP_NONE;
		end
		else if (load_resp)
		begin
			resp <= load_value;
			resp_cnt <= load_count;
		end
		else if (tx_valid && tx_ready)
		begin
			resp <= {resp[BYTE_W-1:0], 8'h00};
			resp_cnt <= 2'(resp_cnt - 1'b1);
		end
	end

	assign tx_valid = (resp_cnt != RESP_NONE);
	assign tx_byte = resp[WORD_W-1:BYTE_W];

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cpu_cmd <= '0;
		end
		else
		begin
			cpu_cmd.step <= take && (rx_byte == CMD_STEP) && allowed;
			cpu_cmd.stuff <= (state == ST_GET_STUFF) && rx_valid;
			cpu_cmd.exec_valid <= rx_valid &&
				((state == ST_EXEC_FIRST) || (state == ST_EXEC_REST));
			cpu_cmd.exec_last <= rx_valid &&
				(((state == ST_EXEC_FIRST) && (first_len == LEN_ONE)) ||
				((state == ST_EXEC_REST) && (exec_left == LEN_ONE)));
			if (rx_valid)
			begin
				cpu_cmd.data <= rx_byte;
			end
		end
	end

endmodule : dci_top

// [tb/dci_top_properties.sv]
// Port checks of the debug command interpreter.
module dci_top_properties
	import dci_pkg::*;
#(
	parameter int unsigned ADDR_W = 11
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic [BYTE_W-1:0] rx_byte,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [BYTE_W-1:0] tx_byte,
	input wire logic read_protect,
	input wire logic cpu_halted,
	input wire logic pmem_rd,
	input wire logic [ADDR_W-1:0] pmem_addr,
	input wire dci_pkg::dci_cpu_cmd_t cpu_cmd,
	input wire logic [BYTE_W-1:0] debugger_control_reg,
	input wire logic [BYTE_W-1:0] debugger_status_reg,
	input wire logic halted_debug_flag,
	input wire logic brk_enable,
	input wire logic device_reset_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	chk_status_bits: assert property (
		debugger_status_reg == {halted_debug_flag, cpu_halted, read_protect, 5'h00})
		else $error("status byte wrong");
	chk_control_bits: assert property (
		halted_debug_flag == debugger_control_reg[7] && brk_enable == debugger_control_reg[6])
		else $error("control flags wrong");
	chk_reset_pulse: assert property (
		debugger_control_reg[0] |=> device_reset_req && !debugger_control_reg[0])
		else $error("reset request wrong");
	chk_protect_sticky: assert property (
		read_protect && halted_debug_flag |=> halted_debug_flag)
		else $error("debug flag cleared");
	chk_sum_start: assert property (
		$rose(pmem_rd) |-> pmem_addr == '0)
		else $error("checksum start address");
	chk_sum_walk: assert property (
		pmem_rd ##1 pmem_rd |-> pmem_addr == $past(pmem_addr) + 1'b1)
		else $error("checksum address skip");
	chk_sum_gated: assert property (
		pmem_rd |-> halted_debug_flag)
		else $error("memory read outside debug");
	chk_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("response dropped");
	chk_step_cause: assert property (
		cpu_cmd.step |-> $past(rx_valid) && $past(rx_byte) == CMD_STEP
		&& $past(halted_debug_flag) && !$past(read_protect))
		else $error("step without cause");
	chk_stuff_data: assert property (
		cpu_cmd.stuff |-> $past(rx_valid) && cpu_cmd.data == $past(rx_byte))
		else $error("stuff byte wrong");
endmodule : dci_top_properties

bind dci_top dci_top_properties #(.ADDR_W(ADDR_W)) dci_top_properties_inst (.*);

// [tb/dci_pmem_model.sv]
// Program memory stand-in answering reads one cycle late.
module dci_pmem_model
(
	input wire logic ref_clk,
	input wire logic pmem_rd,
	input wire logic [3:0] pmem_addr,
	output logic [7:0] pmem_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pmem_data = 8'h00;
	// Between reads the data changes every cycle, so a stale byte is never trusted.
	always @(posedge ref_clk)
		pmem_data <= pmem_rd ? {~pmem_addr, pmem_addr} : ~pmem_data;
endmodule : dci_pmem_model

// [tb/dci_tb_top.sv]
// Self-checking bench of the debug command interpreter.
module dci_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dci_pkg::*;
	localparam int unsigned NB = 16;
	localparam logic [7:0] MAJ = 8'h5a;
	localparam logic [7:0] MIN = 8'h3c;
	logic ref_clk, reset, rx_valid, tx_ready, read_protect, cpu_halted;
	logic tx_valid, pmem_rd, halted_debug_flag, brk_enable, device_reset_req;
	logic [7:0] rx_byte, tx_byte, pmem_data, debugger_control_reg, debugger_status_reg;
	logic [2:0] insn_len;
	logic [3:0] pmem_addr;
	dci_cpu_cmd_t cpu_cmd;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	dci_top #(.PMEM_BYTES(NB), .ADDR_W(4), .REV_MAJOR(MAJ), .REV_MINOR(MIN)) dci_top_inst (.*);
	dci_pmem_model dci_pmem_model_inst (.*);
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task send(input logic [7:0] b);
		@(negedge ref_clk);
		rx_valid = 1'b1;
		rx_byte = b;
		@(negedge ref_clk);
		rx_valid = 1'b0;
	endtask : send
	task get(input logic [7:0] e);
		int i;
		i = 0;
		// One edge passes first, so back-to-back reads never raise ready where it was just lowered.
		@(negedge ref_clk);
		while (tx_valid !== 1'b1 && i < 40)
		begin
			@(negedge ref_clk);
			i++;
		end
		check("response", {tx_valid, tx_byte}, {1'b1, e});
		tx_ready = 1'b1;
		@(negedge ref_clk);
		tx_ready = 1'b0;
	endtask : get
	task quiet();
		repeat (3) @(negedge ref_clk);
		check("idle", tx_valid, 1'b0);
	endtask : quiet
	function automatic logic [15:0] sum_of();
		logic [15:0] c;
		logic [7:0] d;
		c = 16'hffff;
		for (int a = 0; a < NB; a++)
		begin
			d = {~a[3:0], a[3:0]};
			for (int k = 7; k >= 0; k--)
				c = (c[15] ^ d[k]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
		end
		return c;
	endfunction : sum_of
	initial
	begin
		logic [15:0] s;
		logic [7:0] rsv [3];
		rsv = '{8'h01, 8'h13, 8'hff};
		s = sum_of();
		reset = 1'b1;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		insn_len = 3'h1;
		tx_ready = 1'b0;
		read_protect = 1'b0;
		cpu_halted = 1'b1;
		repeat (4) @(negedge ref_clk);
		reset = 1'b0;
		check("control", debugger_control_reg, 8'h00);
		check("status", debugger_status_reg, 8'h40);
		repeat (65600) @(negedge ref_clk);
		send(CMD_READ_TALLY);
		get(8'hff);
		get(8'hff);
		send(8'h08);
		send(CMD_READ_TALLY);
		get(8'h00);
		get(8'h01);
		for (int i = 0; i < 3; i++)
		begin
			send(rsv[i]);
			quiet();
		end
		send(CMD_READ_REV);
		get(MAJ);
		get(MIN);
		send(CMD_WRITE_CTL);
		send(8'h7e);
		check("control", debugger_control_reg, 8'h40);
		check("brk", brk_enable, 1'b1);
		send(CMD_READ_CTL);
		get(8'h40);
		send(CMD_WRITE_CTL);
		send(8'h81);
		check("control", debugger_control_reg, 8'h81);
		check("debug", halted_debug_flag, 1'b1);
		@(negedge ref_clk);
		check("reset", {device_reset_req, debugger_control_reg}, {1'b1, 8'h80});
		send(CMD_READ_STAT);
		get(8'hc0);
		send(CMD_CRC);
		repeat (NB + 1) @(negedge ref_clk);
		check("early", tx_valid, 1'b0);
		@(negedge ref_clk);
		check("ready", tx_valid, 1'b1);
		get(s[15:8]);
		get(s[7:0]);
		send(CMD_STEP);
		check("step", cpu_cmd.step, 1'b1);
		send(CMD_STUFF);
		send(8'ha5);
		check("stuff", {cpu_cmd.stuff, cpu_cmd.data}, {1'b1, 8'ha5});
		send(CMD_EXEC);
		insn_len = 3'h2;
		send(8'hb1);
		check("exec", {cpu_cmd.exec_valid, cpu_cmd.exec_last, cpu_cmd.data}, 10'h2b1);
		send(8'hb2);
		check("exec", {cpu_cmd.exec_valid, cpu_cmd.exec_last, cpu_cmd.data}, 10'h3b2);
		read_protect = 1'b1;
		send(CMD_STEP);
		check("step", cpu_cmd.step, 1'b0);
		send(CMD_EXEC);
		send(CMD_READ_REV);
		check("exec", cpu_cmd.exec_valid, 1'b0);
		quiet();
		send(CMD_STUFF);
		send(CMD_READ_CTL);
		check("stuff", cpu_cmd.stuff, 1'b0);
		get(8'h80);
		send(CMD_WRITE_CTL);
		send(8'h00);
		check("control", debugger_control_reg, 8'h80);
		reset = 1'b1;
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		read_protect = 1'b0;
		check("control", debugger_control_reg, 8'h00);
		send(CMD_CRC);
		get(8'hff);
		get(8'hff);
		cpu_halted = 1'b0;
		send(CMD_READ_STAT);
		get(8'h00);
		end_of_test();
	end
endmodule : dci_tb_top
